// File: core/t16_pkg.sv
// Notes on behaviour
// - Each channel holds a 16-bit down counter preset from its reload register.
// - With debug-run at 0 debug state freezes the channel; at 1 it keeps counting.
// - A source stopped in sleep halts the channel, keeping its state, until wake-up.
// - On an event channel, source code 0x3 counts rising edges of the event input.
// - On other channels, source code 0x3 selects the external oscillator clock.
// - Underflow pulses drive interrupt logic and, in repeat mode, peripheral clocks.
// - Underflow period is reload value plus one counting clocks.
// - Repeat mode runs until stopped, reloading on every underflow.
// - One-shot mode reloads on underflow, stops, and clears the run bit.
// - Underflow sets the flag; only writing 1 clears it.
// - Interrupt request is the flag ANDed with its enable bit.
// - Clock control: debug-run bit 8, divider 7-4, source 1-0, zero reset.
// - Four channels; channels 1 and 2 clock serial masters, channel 3 triggers ADC.
// - Run starts only with channel enable set; writing 0 stops; reads show running.
// - Preset copies reload into counter, reads 1 while pending, then self-clears.
// - Reload and counter reset to 0xFFFF; reload loads on preset or underflow.
// - Divider field selects ratio 1/1 to 1/32768 of the chosen source.
`default_nettype none
package t16_pkg;

  // Channel count and widths.
  localparam int        NUM_CH      = 4;
  localparam int        CNT_W       = 16;
  localparam int        PRE_W       = 15;
  localparam logic [3:0] EVENT_MASK = 4'h1;  // Channels with event counting.

  // Register offsets inside one channel window, and the channel stride.
  localparam logic [4:0] OFS_CLK  = 5'h00;
  localparam logic [4:0] OFS_MOD  = 5'h04;
  localparam logic [4:0] OFS_CTL  = 5'h08;
  localparam logic [4:0] OFS_TR   = 5'h0C;
  localparam logic [4:0] OFS_TC   = 5'h10;
  localparam logic [4:0] OFS_INTF = 5'h14;
  localparam logic [4:0] OFS_INTE = 5'h18;
  localparam int         CH_SHIFT = 5;

  // Field positions.
  localparam int BIT_DEBUG_RUN = 8;
  localparam int LSB_DIV       = 4;
  localparam int LSB_SRC       = 0;
  localparam int BIT_ONESHOT   = 0;
  localparam int BIT_RUN       = 8;
  localparam int BIT_PRESET    = 1;
  localparam int BIT_CHAN_EN   = 0;
  localparam int BIT_UF_FLAG   = 0;
  localparam int BIT_UF_IE     = 0;

  // Reset values and source codes.
  localparam logic [15:0] TR_RESET  = 16'hFFFF;
  localparam logic [15:0] TC_RESET  = 16'hFFFF;
  localparam logic [1:0]  SRC_EXT   = 2'h3;

  // Clock control fields of one channel.
  typedef struct packed {
    logic       debug_run;
    logic [3:0] div;
    logic [1:0] src;
  } clk_cfg_t;

  // Control writes delivered to one channel.
  typedef struct packed {
    logic        ctl_wr;
    logic        intf_wr;
    logic [15:0] wdata;
  } chan_cmd_t;

  // State reported by one channel.
  typedef struct packed {
    logic        chan_en;
    logic        run;
    logic        preset;
    logic        flag;
    logic        uf;
    logic [15:0] count;
  } chan_stat_t;

endpackage
`default_nettype wire

// File: core/count_clock_gen.sv
`timescale 1ns/1ps
`default_nettype none
module count_clock_gen (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire t16_pkg::clk_cfg_t cfg,
  input  wire logic              event_capable,
  input  wire logic [3:0]        src_level,
  input  wire logic              event_level,
  input  wire logic              sleep_mode,
  input  wire logic [3:0]        sleep_stop_control,
  input  wire logic              debug_mode,
  input  wire logic              chan_en,
  output logic                   supply,
  output logic                   count_tick
);

  logic [4:0]                 prev_q;
  logic [4:0]                 prev_d;
  logic [t16_pkg::PRE_W-1:0]  pre_q;
  logic [t16_pkg::PRE_W-1:0]  pre_d;
  logic [t16_pkg::PRE_W-1:0]  mask;
  logic [4:0]                 rise;
  logic                       src_tick;

  // Rising edges of every source and the event input.
  assign prev_d = {event_level, src_level};
  assign rise   = prev_d & ~prev_q;

  // Source 0x3 is the event input on event channels, else the external clock.
  always_comb begin
    if (cfg.src == t16_pkg::SRC_EXT && event_capable) begin
      src_tick = rise[4];
    end else begin
      src_tick = rise[cfg.src];
    end
  end

  // Clock supply gating by enable, debug and sleep stop.
  assign supply = chan_en
                  & ~(debug_mode & ~cfg.debug_run)
                  & ~(sleep_mode & sleep_stop_control[cfg.src]);

  // Divider: one tick per 2^div source edges.
  assign mask       = t16_pkg::PRE_W'((16'h1 << cfg.div) - 16'h1);
  assign count_tick = supply & src_tick & ((pre_q & mask) == mask);

  // Next prescaler value.
  always_comb begin
    pre_d = pre_q;
    if (!chan_en) begin
      pre_d = '0;
    end else if (supply && src_tick) begin
      pre_d = pre_q + t16_pkg::PRE_W'(1);
    end
  end

  // Register edge history and prescaler.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_q <= 5'h00;
      pre_q  <= '0;
    end else begin
      prev_q <= prev_d;
      pre_q  <= pre_d;
    end
  end

endmodule // count_clock_gen
`default_nettype wire

// File: core/timer_channel.sv
`timescale 1ns/1ps
`default_nettype none
module timer_channel (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               supply,
  input  wire logic               count_tick,
  input  wire logic               oneshot,
  input  wire logic [15:0]        reload,
  input  wire t16_pkg::chan_cmd_t cmd,
  output t16_pkg::chan_stat_t     stat
);

  logic        chan_en_q, chan_en_d;
  logic        run_q, run_d;
  logic        pre_q, pre_d;
  logic        flag_q, flag_d;
  logic        uf_q, uf_d;
  logic [15:0] cnt_q, cnt_d;

  // Counter, run, preset and flag next state.
  always_comb begin
    chan_en_d = chan_en_q;
    run_d   = run_q;
    pre_d   = pre_q;
    cnt_d   = cnt_q;
    uf_d    = 1'b0;
    if (pre_q && supply) begin
      cnt_d = reload;
      pre_d = 1'b0;
    end else if (run_q && count_tick) begin
      if (cnt_q == 16'h0000) begin
        uf_d  = 1'b1;
        cnt_d = reload;
        if (oneshot) begin
          run_d = 1'b0;
        end
      end else begin
        cnt_d = cnt_q - 16'h0001;
      end
    end
    if (cmd.ctl_wr) begin
      chan_en_d = cmd.wdata[t16_pkg::BIT_CHAN_EN];
      run_d     = cmd.wdata[t16_pkg::BIT_RUN] & cmd.wdata[t16_pkg::BIT_CHAN_EN];
      if (cmd.wdata[t16_pkg::BIT_PRESET] && cmd.wdata[t16_pkg::BIT_CHAN_EN]) begin
        pre_d = 1'b1;
      end
    end
    // A new underflow wins over a clear in the same cycle.
    flag_d = (flag_q & ~(cmd.intf_wr & cmd.wdata[t16_pkg::BIT_UF_FLAG])) | uf_d;
  end

  // Register channel state.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_en_q <= 1'b0;
      run_q   <= 1'b0;
      pre_q   <= 1'b0;
      flag_q  <= 1'b0;
      uf_q    <= 1'b0;
      cnt_q   <= t16_pkg::TC_RESET;
    end else begin
      chan_en_q <= chan_en_d;
      run_q   <= run_d;
      pre_q   <= pre_d;
      flag_q  <= flag_d;
      uf_q    <= uf_d;
      cnt_q   <= cnt_d;
    end
  end

  assign stat = '{chan_en: chan_en_q, run: run_q, preset: pre_q,
                  flag: flag_q, uf: uf_q, count: cnt_q};

endmodule // timer_channel
`default_nettype wire

// File: core/presettable_down_timer.sv
`timescale 1ns/1ps
`default_nettype none
module presettable_down_timer (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Clock sources and event inputs.
  input  wire logic        internal_oscillator,
  input  wire logic        low_speed_oscillator,
  input  wire logic        high_speed_oscillator,
  input  wire logic        external_oscillator_clock,
  input  wire logic [3:0]  event_input,
  // Power and debug state.
  input  wire logic        sleep_mode,
  input  wire logic [3:0]  sleep_stop_control,
  input  wire logic        debug_mode,
  // Interrupts and peripheral clocks.
  output logic [3:0]       irq,
  output logic             ssi0_master_clock,
  output logic             ssi1_master_clock,
  output logic             adc_trigger
);

  // ---------------------------------------------------------------
  // Bus pipeline
  // ---------------------------------------------------------------

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_RD_WAIT,
    BUS_RD_DONE
  } bus_state_t;

  bus_state_t  bus_q;
  bus_state_t  bus_d;
  logic [6:0]  addr_q;
  logic [6:0]  addr_d;
  logic        hit_q;
  logic        hit_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        accept;

  // An address phase is taken when selected, active and the bus is ready.
  assign accept    = hsel & htrans[1] & hready;
  assign hreadyout = (bus_q != BUS_RD_WAIT);
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // ---------------------------------------------------------------
  // Channel storage
  // ---------------------------------------------------------------

  t16_pkg::clk_cfg_t   cfg_q [t16_pkg::NUM_CH];
  t16_pkg::clk_cfg_t   cfg_d [t16_pkg::NUM_CH];
  logic                mode_q [t16_pkg::NUM_CH];
  logic                mode_d [t16_pkg::NUM_CH];
  logic                ie_q [t16_pkg::NUM_CH];
  logic                ie_d [t16_pkg::NUM_CH];
  logic [15:0]         tr_q [t16_pkg::NUM_CH];
  logic [15:0]         tr_d [t16_pkg::NUM_CH];
  t16_pkg::chan_cmd_t  cmd [t16_pkg::NUM_CH];
  t16_pkg::chan_stat_t stat [t16_pkg::NUM_CH];
  logic [2:0]          per_q;
  logic [2:0]          per_d;
  logic [1:0]          wch;
  logic [4:0]          wofs;
  logic                wr_en;

  assign wch   = addr_q[6:5];
  assign wofs  = addr_q[4:0];
  assign wr_en = (bus_q == BUS_WRITE) & hit_q;

  // ---------------------------------------------------------------
  // Bus next state and read data
  // ---------------------------------------------------------------

  // Track phases; reads take one wait state so a prior write is visible.
  always_comb begin
    bus_d   = bus_q;
    addr_d  = addr_q;
    hit_d   = hit_q;
    rdata_d = rdata_q;
    if (bus_q == BUS_RD_WAIT) begin
      bus_d = BUS_RD_DONE;
      if (hit_q) begin
        unique case (wofs)
          t16_pkg::OFS_CLK: begin
            rdata_d = {23'h0, cfg_q[wch].debug_run, cfg_q[wch].div,
                       2'h0, cfg_q[wch].src};
          end
          t16_pkg::OFS_MOD: begin
            rdata_d = {31'h0, mode_q[wch]};
          end
          t16_pkg::OFS_CTL: begin
            rdata_d = {23'h0, stat[wch].run, 6'h0,
                       stat[wch].preset, stat[wch].chan_en};
          end
          t16_pkg::OFS_TR: begin
            rdata_d = {16'h0, tr_q[wch]};
          end
          t16_pkg::OFS_TC: begin
            rdata_d = {16'h0, stat[wch].count};
          end
          t16_pkg::OFS_INTF: begin
            rdata_d = {31'h0, stat[wch].flag};
          end
          t16_pkg::OFS_INTE: begin
            rdata_d = {31'h0, ie_q[wch]};
          end
          default: begin
            rdata_d = 32'h0000_0000;
          end
        endcase
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end else if (accept) begin
      bus_d  = hwrite ? BUS_WRITE : BUS_RD_WAIT;
      addr_d = haddr[6:0];
      hit_d  = (haddr[31:7] == 25'h0) & (hsize == 3'h2);
    end else begin
      bus_d = BUS_IDLE;
    end
  end

  // Register bus state.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_q   <= BUS_IDLE;
      addr_q  <= 7'h00;
      hit_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      bus_q   <= bus_d;
      addr_q  <= addr_d;
      hit_q   <= hit_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------

  // Writes in the data phase update the addressed channel.
  always_comb begin
    for (int i = 0; i < t16_pkg::NUM_CH; i++) begin
      cfg_d[i]  = cfg_q[i];
      mode_d[i] = mode_q[i];
      ie_d[i]   = ie_q[i];
      tr_d[i]   = tr_q[i];
      if (wr_en && wch == 2'(i)) begin
        unique case (wofs)
          t16_pkg::OFS_CLK: begin
            cfg_d[i].debug_run = hwdata[t16_pkg::BIT_DEBUG_RUN];
            cfg_d[i].div   = hwdata[t16_pkg::LSB_DIV +: 4];
            cfg_d[i].src   = hwdata[t16_pkg::LSB_SRC +: 2];
          end
          t16_pkg::OFS_MOD: begin
            mode_d[i] = hwdata[t16_pkg::BIT_ONESHOT];
          end
          t16_pkg::OFS_TR: begin
            tr_d[i] = hwdata[15:0];
          end
          t16_pkg::OFS_INTE: begin
            ie_d[i] = hwdata[t16_pkg::BIT_UF_IE];
          end
          default: begin
            ie_d[i] = ie_q[i];
          end
        endcase
      end
    end
  end

  // Register configuration; counting keeps reload and settings intact.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < t16_pkg::NUM_CH; i++) begin
        cfg_q[i]  <= '0;
        mode_q[i] <= 1'b0;
        ie_q[i]   <= 1'b0;
        tr_q[i]   <= t16_pkg::TR_RESET;
      end
    end else begin
      for (int i = 0; i < t16_pkg::NUM_CH; i++) begin
        cfg_q[i]  <= cfg_d[i];
        mode_q[i] <= mode_d[i];
        ie_q[i]   <= ie_d[i];
        tr_q[i]   <= tr_d[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------

  // One clock generator and one counter per channel.
  for (genvar g = 0; g < t16_pkg::NUM_CH; g++) begin : g_ch
    logic supply;
    logic tick;

    assign cmd[g].ctl_wr  = wr_en & (wch == 2'(g)) & (wofs == t16_pkg::OFS_CTL);
    assign cmd[g].intf_wr = wr_en & (wch == 2'(g)) & (wofs == t16_pkg::OFS_INTF);
    assign cmd[g].wdata   = hwdata[15:0];

    count_clock_gen u_clk (
      .clk                (clk),
      .sys_rst            (sys_rst),
      .cfg                (cfg_q[g]),
      .event_capable      (t16_pkg::EVENT_MASK[g]),
      .src_level          ({external_oscillator_clock, high_speed_oscillator,
                            low_speed_oscillator, internal_oscillator}),
      .event_level        (event_input[g]),
      .sleep_mode         (sleep_mode),
      .sleep_stop_control (sleep_stop_control),
      .debug_mode         (debug_mode),
      .chan_en            (stat[g].chan_en),
      .supply             (supply),
      .count_tick         (tick)
    );

    timer_channel u_chan (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .supply     (supply),
      .count_tick (tick),
      .oneshot    (mode_q[g]),
      .reload     (tr_q[g]),
      .cmd        (cmd[g]),
      .stat       (stat[g])
    );

    // Interrupt request only while flag and enable are both set.
    assign irq[g] = stat[g].flag & ie_q[g];
  end

  // ---------------------------------------------------------------
  // Peripheral outputs
  // ---------------------------------------------------------------

  // Underflow pulses of channels 1..3 go out only in repeat mode.
  always_comb begin
    per_d[0] = stat[1].uf & ~mode_q[1];
    per_d[1] = stat[2].uf & ~mode_q[2];
    per_d[2] = stat[3].uf & ~mode_q[3];
  end

  // Register peripheral pulses.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      per_q <= 3'h0;
    end else begin
      per_q <= per_d;
    end
  end

  assign ssi0_master_clock = per_q[0];
  assign ssi1_master_clock = per_q[1];
  assign adc_trigger       = per_q[2];

endmodule // presettable_down_timer
`default_nettype wire

// File: sim/presettable_down_timer_props.sv
`timescale 1ns/1ps
`default_nettype none
module presettable_down_timer_chk (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic [3:0]  irq,
  input wire logic        ssi0_master_clock,
  input wire logic        ssi1_master_clock,
  input wire logic        adc_trigger
);
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic rd_taken;
  logic wr_taken;

  // Transfers accepted at an edge, split by direction.
  assign rd_taken = hsel && htrans[1] && hready && !hwrite;
  assign wr_taken = hsel && htrans[1] && hready && hwrite;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (rd_taken |=> !hreadyout)
    else $error("read data phase without wait state");
  a_write_nowait: assert property (wr_taken |=> hreadyout)
    else $error("write data phase stalled");
  a_wait_single: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  a_rdata_upper: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read data bits not zero");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0)
    else $error("read data changed outside a read");
  a_irq_clear: assert property (|($past(irq) & ~irq) |-> $past(wr_taken, 2))
    else $error("interrupt dropped without a write");
  a_ssi0_pulse: assert property (ssi0_master_clock |=> !ssi0_master_clock)
    else $error("serial clock 0 pulse too long");
  a_ssi1_pulse: assert property (ssi1_master_clock |=> !ssi1_master_clock)
    else $error("serial clock 1 pulse too long");
  a_adc_pulse: assert property (adc_trigger |=> !adc_trigger)
    else $error("converter trigger pulse too long");
endmodule  // presettable_down_timer_chk

bind presettable_down_timer presettable_down_timer_chk u_chk (
  .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
  .ssi0_master_clock(ssi0_master_clock), .ssi1_master_clock(ssi1_master_clock),
  .adc_trigger(adc_trigger)
);
`default_nettype wire

// File: sim/test_presettable_down_timer.sv
`timescale 1ns/1ps
`default_nettype none
module test_presettable_down_timer;
  logic        clk, sys_rst, hsel, hwrite, hreadyout, hresp;
  logic        sleep_mode, debug_mode, ssi0, ssi1, adc;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  srcv;
  logic [3:0]  ssc, irq;
  int          err_count, comparisons, rr;
  integer      seed = 32'h9872;
  int          cnt[4], rel[4], flg[4], run[4], one[4], ufs[4], en[4], ie[4], pre[4], dv[4];
  int          np[4];

  presettable_down_timer dut (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .internal_oscillator(srcv[0]), .low_speed_oscillator(srcv[1]),
    .high_speed_oscillator(srcv[2]), .external_oscillator_clock(srcv[3]),
    .event_input(srcv[7:4]), .sleep_mode(sleep_mode), .sleep_stop_control(ssc),
    .debug_mode(debug_mode), .irq(irq), .ssi0_master_clock(ssi0),
    .ssi1_master_clock(ssi1), .adc_trigger(adc)
  );

  // ----------------------------------------
  // Clock, pulse monitor and watchdog
  // ----------------------------------------
  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Counts peripheral pulses of channels 1 to 3.
  always @(posedge clk) begin
    np[1] += ssi0;
    np[2] += ssi1;
    np[3] += adc;
  end

  // Cuts a hang short well after the expected run length.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize();
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One single word transfer; read data lands in rd.
  task automatic xfer(input bit wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Brings a channel up in the documented order and starts it.
  task automatic setup(input int ch, input int src, input int div, input int o, input int r);
    xfer(1, ch * 32, (div << 4) | src);
    xfer(1, ch * 32 + 8, 32'h1);
    xfer(1, ch * 32 + 4, o);
    xfer(1, ch * 32 + 12, r);
    xfer(1, ch * 32 + 20, 32'h1);
    xfer(1, ch * 32 + 24, 32'h1);
    xfer(1, ch * 32 + 8, 32'h103);
    dv[ch] = div; pre[ch] = 0; one[ch] = o; rel[ch] = r; cnt[ch] = r;
    flg[ch] = 0; ie[ch] = 1; en[ch] = 1; run[ch] = 1;
  endtask

  // Makes n source edges on srcv[idx]; live tells whether channel ch sees them.
  task automatic pulse(input int idx, input int n, input int ch, input bit live);
    bit tk;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      srcv[idx] <= 1'b1;
      @(posedge clk);
      srcv[idx] <= 1'b0;
      if (live) begin
        tk = (pre[ch] % (1 << dv[ch])) == (1 << dv[ch]) - 1;
        pre[ch]++;
        if (tk && run[ch] != 0) begin
          if (cnt[ch] == 0) begin
            cnt[ch] = rel[ch];
            flg[ch] = 1;
            if (one[ch] != 0) run[ch] = 0;
            else ufs[ch]++;
          end else cnt[ch]--;
        end
      end
    end
    repeat (6) @(posedge clk);
  endtask

  task automatic check_ch(input int ch);
    xfer(0, ch * 32 + 8, 0);
    cmp(rd, (run[ch] << 8) | en[ch], "control");
    xfer(0, ch * 32 + 16, 0);
    cmp(rd, cnt[ch], "count");
    xfer(0, ch * 32 + 20, 0);
    cmp(rd, flg[ch], "flag");
    cmp(irq[ch], flg[ch] & ie[ch], "irq");
    if (ch > 0) cmp(np[ch], ufs[ch], "pulses");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; srcv = 8'h00; ssc = 4'h0;
    sleep_mode = 1'b0; debug_mode = 1'b0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 7; r++) begin
        xfer(0, c * 32 + r * 4, 0);
        cmp(rd, (r == 3 || r == 4) ? 32'h0000FFFF : 32'h0, "reset value");
      end
    end
    xfer(0, 32'h80, 0);
    cmp(rd, 32'h0, "unmapped read");
    rr = $random(seed);
    xfer(1, 32'h0, rr);
    xfer(0, 32'h0, 0);
    cmp(rd, rr & 32'h1F3, "clock control");
    xfer(1, 32'h0, 32'h0);
    xfer(1, 32'h8, 32'h100);
    xfer(0, 32'h8, 0);
    cmp(rd, 32'h0, "run without enable");
    // Repeat mode on channel 1, then flag clear.
    rr = 2 + ($unsigned($random(seed)) % 6);
    setup(1, 0, 0, 0, rr);
    pulse(0, 3 * (rr + 1) + 2, 1, 1);
    check_ch(1);
    xfer(1, 32'h34, 32'h1);
    flg[1] = 0;
    check_ch(1);
    // Debug freeze, then debug-run.
    debug_mode <= 1'b1;
    pulse(0, 5, 1, 0);
    check_ch(1);
    // A preset asked for while the clock is withheld stays pending.
    xfer(1, 32'h28, 32'h103);
    xfer(0, 32'h28, 0);
    cmp(rd, 32'h103, "preset pending");
    xfer(1, 32'h20, 32'h100);
    cnt[1] = rel[1];
    pulse(0, 4, 1, 1);
    check_ch(1);
    debug_mode <= 1'b0;
    // Source stopped in sleep, then resumed.
    sleep_mode <= 1'b1;
    ssc <= 4'h1;
    pulse(0, 5, 1, 0);
    check_ch(1);
    sleep_mode <= 1'b0;
    pulse(0, 3, 1, 1);
    check_ch(1);
    xfer(1, 32'h28, 32'h1);
    run[1] = 0;
    pulse(0, 3, 1, 1);
    check_ch(1);
    // One-shot on channel 3.
    setup(3, 1, 0, 1, rr);
    pulse(1, rr + 4, 3, 1);
    check_ch(3);
    // Event counting on channel 0, oscillator on channel 2.
    setup(0, 3, 0, 0, rr);
    pulse(4, rr + 3, 0, 1);
    pulse(3, 4, 0, 0);
    check_ch(0);
    setup(2, 3, 0, 0, rr);
    pulse(6, 3, 2, 0);
    pulse(3, rr + 3, 2, 1);
    check_ch(2);
    // Divided clock on channel 1 after a disable.
    xfer(1, 32'h28, 32'h0);
    setup(1, 0, 2, 0, rr);
    pulse(0, 4 * (rr + 1) + 5, 1, 1);
    check_ch(1);
    summarize();
  end
endmodule  // test_presettable_down_timer
`default_nettype wire
